/* design/dcsc_map.vh */
// Bit positions, event codes, context kinds and source selects for the DMA context state control block
`ifndef DCSC_MAP_VH
`define DCSC_MAP_VH
`define DCSC_RUN_BIT 15
`define DCSC_WAKE_BIT 12
`define DCSC_DEAD_BIT 11
`define DCSC_ACTIVE_BIT 10
`define DCSC_SPD_HI 7
`define DCSC_SPD_LO 5
`define DCSC_EVT_HI 4
`define DCSC_EVT_LO 0
`define DCSC_CNT_HI 3
`define DCSC_CNT_LO 0
`define DCSC_ADDR_HI 31
`define DCSC_ADDR_LO 4
`define DCSC_EVT_NO_STATUS 5'h00
`define DCSC_EVT_LONG_PACKET 5'h02
`define DCSC_EVT_MISSING_ACK 5'h03
`define DCSC_EVT_UNDERRUN 5'h04
`define DCSC_EVT_OVERRUN 5'h05
`define DCSC_EVT_DESC_READ 5'h06
`define DCSC_EVT_DATA_READ 5'h07
`define DCSC_EVT_DATA_WRITE 5'h08
`define DCSC_EVT_BUS_RESET 5'h09
`define DCSC_EVT_TIMEOUT 5'h0A
`define DCSC_EVT_TCODE_ERR 5'h0B
`define DCSC_EVT_UNKNOWN 5'h0E
`define DCSC_EVT_FLUSHED 5'h0F
`define DCSC_ACK_COMPLETE 5'h11
`define DCSC_ACK_PENDING 5'h12
`define DCSC_ACK_BUSY_X 5'h14
`define DCSC_ACK_BUSY_A 5'h15
`define DCSC_ACK_BUSY_B 5'h16
`define DCSC_ACK_TARDY 5'h1B
`define DCSC_ACK_DATA_ERROR 5'h1D
`define DCSC_ACK_TYPE_ERROR 5'h1E
`define DCSC_KIND_AT 2'h0
`define DCSC_KIND_AR 2'h1
`define DCSC_KIND_IT 2'h2
`define DCSC_KIND_IR 2'h3
`define DCSC_SRC_NONE 4'h0
`define DCSC_SRC_DESC_RD 4'h1
`define DCSC_SRC_DATA_RD 4'h2
`define DCSC_SRC_DATA_WR 4'h3
`define DCSC_SRC_MISS_ACK 4'h4
`define DCSC_SRC_UNDERRUN 4'h5
`define DCSC_SRC_TCODE 4'h6
`define DCSC_SRC_LONG 4'h7
`define DCSC_SRC_OVERRUN 4'h8
`define DCSC_SRC_TIMEOUT 4'h9
`define DCSC_SRC_FLUSHED 4'hA
`define DCSC_SRC_BUSRST_PKT 4'hB
`define DCSC_SRC_ACK 4'hC
`define DCSC_SRC_RETRY_OUT 4'hD
`define DCSC_SRC_NO_ACK 4'hE
`define DCSC_SRC_OTHER 4'hF
`endif

/* design/dcsc_event_encode.v */
// Maps a packet outcome onto the five-bit context event code
`timescale 1ns/1ps
`include "dcsc_map.vh"
module dcsc_event_encode (
    input wire [3:0] src,
    input wire [4:0] ack_code,
    input wire [1:0] last_busy,
    output reg [4:0] code
);
    always @* begin
        case (src)
            `DCSC_SRC_NONE: code = `DCSC_EVT_NO_STATUS; // [RQ7]
            `DCSC_SRC_DESC_RD: code = `DCSC_EVT_DESC_READ; // [RQ3]
            `DCSC_SRC_DATA_RD: code = `DCSC_EVT_DATA_READ; // [RQ3]
            `DCSC_SRC_DATA_WR: code = `DCSC_EVT_DATA_WRITE; // [RQ3]
            `DCSC_SRC_MISS_ACK: code = `DCSC_EVT_MISSING_ACK; // [RQ4]
            `DCSC_SRC_UNDERRUN: code = `DCSC_EVT_UNDERRUN; // [RQ4]
            `DCSC_SRC_TCODE: code = `DCSC_EVT_TCODE_ERR; // [RQ4]
            `DCSC_SRC_LONG: code = `DCSC_EVT_LONG_PACKET; // [RQ5]
            `DCSC_SRC_OVERRUN: code = `DCSC_EVT_OVERRUN; // [RQ5]
            `DCSC_SRC_BUSRST_PKT: code = `DCSC_EVT_BUS_RESET; // [RQ6]
            `DCSC_SRC_TIMEOUT: code = `DCSC_EVT_TIMEOUT; // [RQ6]
            `DCSC_SRC_FLUSHED: code = `DCSC_EVT_FLUSHED; // [RQ6]
            `DCSC_SRC_NO_ACK: code = `DCSC_ACK_COMPLETE; // [RQ8]
            `DCSC_SRC_RETRY_OUT: begin
                case (last_busy) // [RQ9]
                    2'h1: code = `DCSC_ACK_BUSY_A;
                    2'h2: code = `DCSC_ACK_BUSY_B;
                    default: code = `DCSC_ACK_BUSY_X;
                endcase
            end
            `DCSC_SRC_ACK: begin
                // Only defined acks pass; reserved slots become unknown
                case (ack_code)
                    `DCSC_ACK_COMPLETE, `DCSC_ACK_PENDING: code = ack_code; // [RQ8]
                    `DCSC_ACK_BUSY_X, `DCSC_ACK_BUSY_A, `DCSC_ACK_BUSY_B: code = ack_code;
                    `DCSC_ACK_TARDY, `DCSC_ACK_DATA_ERROR, `DCSC_ACK_TYPE_ERROR: code = ack_code; // [RQ10]
                    default: code = `DCSC_EVT_UNKNOWN; // [RQ7]
                endcase
            end
            default: code = `DCSC_EVT_UNKNOWN; // [RQ7]
        endcase
    end
endmodule

/* design/dcsc_context.v */
// Run, wake, active and dead control for one DMA context with list walking
// Notes on behaviour
// RQ1: Event field is five bits; controller codes have bit four clear; low 16 bits are status.
// RQ2: Run bit 15, wake 12, dead 11, active 10, event 4..0; receive adds speed.
// RQ3: Memory failures: 06h descriptor read, 07h data read, 08h data or status write.
// RQ4: Transmit reports 03h missing ack, 04h underrun, 0Bh bad transaction code.
// RQ5: Isochronous receive reports 02h long packet, 05h FIFO overflow.
// RQ6: 09h bus-reset packet tag, 0Ah response timeout, 0Fh flushed by bus reset.
// RQ7: 00h no status, 0Eh other error; reserved codes never produced.
// RQ8: 11h accepted and complete, 12h pending; ackless packets get 11h.
// RQ9: Retries exhausted report 14h, 15h or 16h by last busy variant.
// RQ10: 1Bh suspended target, 1Dh payload CRC or length, 1Eh type error.
// RQ11: Software sets run only with active clear and a valid pointer.
// RQ12: Clearing run stops this context alone, then clears active.
// RQ13: Isochronous contexts finish the current packet and status before stopping.
// RQ14: Software should reload pointer before restarting run.
// RQ15: Zero branch count causes a reread of the pointer before ending.
// RQ16: Transmit and buffer-fill receive end on zero reread, else continue.
// RQ17: Async receive with zero reread answers busy, keeps count, flushes, stays active.
// RQ18: Wake is cleared before every descriptor read or reread.
// RQ19: Only hardware changes active; set by run, or wake while running.
// RQ20: Active clears on zero branch, safe stop, dead, and reset.
// RQ21: Async transmit contexts clear active on serial-bus reset.
// RQ22: Active clearing while run is clear raises the context interrupt event.
// RQ23: Dead clears active, keeps run, raises unrecoverable error, blocks context event.
// RQ24: Invalid descriptor count sets dead with the unknown code, no processing.
// RQ25: Pointer holds block address in bits 31..4 and count in bits 3..0.
`timescale 1ns/1ps
`include "dcsc_map.vh"
module dcsc_context (
    input wire clk,
    input wire rstn,
    input wire clk_en,
    input wire soft_reset,
    input wire [1:0] ctx_kind,
    input wire buffer_fill_cfg,
    input wire ctl_wr_set,
    input wire ctl_wr_clr,
    input wire [31:0] ctl_wdata,
    input wire ptr_wr,
    input wire [31:0] ptr_wdata,
    input wire serial_bus_reset,
    input wire [3:0] max_count,
    input wire desc_done,
    input wire [31:0] desc_branch,
    input wire desc_int_req,
    input wire pkt_done,
    input wire [3:0] pkt_src,
    input wire [4:0] pkt_ack,
    input wire [1:0] pkt_last_busy,
    input wire [2:0] pkt_speed,
    input wire pkt_in_progress,
    input wire safe_point,
    input wire rx_arrival,
    input wire fatal_err,
    input wire [3:0] fatal_src,
    output reg [31:0] ctl_rdata,
    output reg [31:0] descriptor_list_pointer,
    output reg desc_fetch_req,
    output reg [31:0] desc_fetch_addr,
    output reg rx_busy_ack,
    output reg rx_flush,
    output reg context_int_event,
    output reg unrecoverable_int_event,
    output reg [15:0] status_word
);
    localparam ST_IDLE = 3'h0;
    localparam ST_FETCH = 3'h1;
    localparam ST_WAIT = 3'h2;
    localparam ST_RUN = 3'h3;
    localparam ST_REREAD = 3'h4;
    localparam ST_REWAIT = 3'h5;
    localparam ST_PARK = 3'h6;

    reg [2:0] st_q;
    reg [2:0] st_d;
    reg run_q;
    reg wake_q;
    reg dead_q;
    reg active_q;
    reg [4:0] evt_q;
    reg [2:0] spd_q;
    reg [31:0] ptr_q;
    reg busy_q;
    reg flush_q;
    reg cint_q;
    reg uint_q;
    reg [31:0] fetch_addr_q;
    reg fetch_q;
    reg run_d;
    reg wake_d;
    reg dead_d;
    reg active_d;
    reg [4:0] evt_d;
    reg [2:0] spd_d;
    reg [31:0] ptr_d;
    reg busy_d;
    reg flush_d;
    reg cint_d;
    reg uint_d;
    reg [31:0] fetch_addr_d;
    reg fetch_d;
    reg set_run;
    reg set_wake;
    reg clr_run;
    reg stop_now;
    wire is_isoch;
    wire is_rx;
    wire count_bad;
    wire branch_bad;
    wire [4:0] pkt_code;
    wire [4:0] fatal_code;

    assign is_isoch = ctx_kind[1];
    assign is_rx = ctx_kind[0];
    assign count_bad = (ptr_q[`DCSC_CNT_HI:`DCSC_CNT_LO] == 4'h0)
        || (ptr_q[`DCSC_CNT_HI:`DCSC_CNT_LO] > max_count);
    assign branch_bad = desc_branch[`DCSC_CNT_HI:`DCSC_CNT_LO] > max_count;

    dcsc_event_encode u_pkt_enc (
        .src(pkt_src),
        .ack_code(pkt_ack),
        .last_busy(pkt_last_busy),
        .code(pkt_code)
    );

    dcsc_event_encode u_fatal_enc (
        .src(fatal_src),
        .ack_code(5'h00),
        .last_busy(2'h0),
        .code(fatal_code)
    );

    always @* begin
        st_d = st_q;
        run_d = run_q;
        wake_d = wake_q;
        dead_d = dead_q;
        active_d = active_q;
        evt_d = evt_q;
        spd_d = spd_q;
        ptr_d = ptr_q;
        busy_d = 1'b0;
        flush_d = 1'b0;
        cint_d = 1'b0;
        uint_d = 1'b0;
        fetch_addr_d = fetch_addr_q;
        fetch_d = 1'b0;
        stop_now = 1'b0;
        set_run = ctl_wr_set && ctl_wdata[`DCSC_RUN_BIT] && !run_q;
        set_wake = ctl_wr_set && ctl_wdata[`DCSC_WAKE_BIT];
        clr_run = ctl_wr_clr && ctl_wdata[`DCSC_RUN_BIT];
        // Pointer writes only take effect while stopped
        if (ptr_wr && !run_q && !active_q) begin
            ptr_d = ptr_wdata; // [RQ25]
        end
        if (set_run) begin
            run_d = 1'b1;
            if (count_bad) begin
                dead_d = 1'b1; // [RQ24]
                evt_d = `DCSC_EVT_UNKNOWN; // [RQ24]
                uint_d = 1'b1; // [RQ23]
            end else begin
                active_d = 1'b1; // [RQ19]
                st_d = ST_FETCH;
            end
        end
        if (set_wake && (run_q || set_run)) begin
            wake_d = 1'b1; // [RQ19]
            if (run_q && !dead_q && !active_q) begin
                active_d = 1'b1; // [RQ19]
                st_d = ST_REREAD;
            end
        end
        if (clr_run) begin
            run_d = 1'b0;
            dead_d = 1'b0; // [RQ23]
            wake_d = 1'b0;
        end
        if (pkt_done) begin
            evt_d = pkt_code; // [RQ1]
            if (is_rx) begin
                spd_d = pkt_speed; // [RQ2]
            end
        end
        case (st_q)
            ST_IDLE: begin
            end
            ST_FETCH: begin
                wake_d = 1'b0; // [RQ18]
                fetch_d = 1'b1;
                fetch_addr_d = {ptr_q[`DCSC_ADDR_HI:`DCSC_ADDR_LO], 4'h0};
                st_d = ST_WAIT;
            end
            ST_WAIT: begin
                if (desc_done) begin
                    if (branch_bad) begin
                        dead_d = 1'b1; // [RQ24]
                        evt_d = `DCSC_EVT_UNKNOWN; // [RQ24]
                        uint_d = 1'b1; // [RQ23]
                        active_d = 1'b0; // [RQ23]
                        st_d = ST_IDLE;
                    end else begin
                        if (desc_int_req) begin
                            cint_d = 1'b1;
                        end
                        if (desc_branch[`DCSC_CNT_HI:`DCSC_CNT_LO] == 4'h0) begin
                            st_d = ST_REREAD; // [RQ15]
                        end else begin
                            ptr_d = desc_branch;
                            st_d = ST_RUN;
                        end
                    end
                end
            end
            ST_RUN: begin
                st_d = ST_FETCH;
            end
            ST_REREAD: begin
                wake_d = 1'b0; // [RQ18]
                fetch_d = 1'b1;
                fetch_addr_d = {ptr_q[`DCSC_ADDR_HI:`DCSC_ADDR_LO], 4'h0}; // [RQ15]
                st_d = ST_REWAIT;
            end
            ST_REWAIT: begin
                if (desc_done) begin
                    if (branch_bad) begin
                        dead_d = 1'b1; // [RQ24]
                        evt_d = `DCSC_EVT_UNKNOWN;
                        uint_d = 1'b1;
                        active_d = 1'b0; // [RQ23]
                        st_d = ST_IDLE;
                    end else if (desc_branch[`DCSC_CNT_HI:`DCSC_CNT_LO] != 4'h0) begin
                        ptr_d = desc_branch; // [RQ16]
                        st_d = ST_RUN;
                    end else if (!is_isoch && is_rx && !buffer_fill_cfg) begin
                        st_d = ST_PARK; // [RQ17]
                    end else begin
                        active_d = 1'b0; // [RQ16]
                        st_d = ST_IDLE;
                    end
                end
            end
            ST_PARK: begin
                // List out of space: busy incoming packets, stay active
                if (rx_arrival) begin
                    busy_d = 1'b1; // [RQ17]
                    flush_d = 1'b1; // [RQ17]
                end
                if (wake_q) begin
                    st_d = ST_REREAD;
                end
            end
            default: st_d = ST_IDLE;
        endcase
        if (fatal_err && active_q) begin
            dead_d = 1'b1; // [RQ23]
            evt_d = fatal_code; // [RQ3]
            uint_d = 1'b1; // [RQ23]
            active_d = 1'b0; // [RQ20]
            fetch_d = 1'b0;
            st_d = ST_IDLE;
        end
        // Stop point: isoch waits out the current packet
        if (!run_q && active_q && (is_isoch ? !pkt_in_progress : safe_point)) begin // [RQ13]
            stop_now = 1'b1;
        end
        if (stop_now) begin
            active_d = 1'b0; // [RQ12]
            fetch_d = 1'b0;
            st_d = ST_IDLE;
        end
        if (serial_bus_reset && ctx_kind == `DCSC_KIND_AT && active_q) begin
            active_d = 1'b0; // [RQ21]
            fetch_d = 1'b0;
            st_d = ST_IDLE;
        end
        if (dead_d) begin
            active_d = 1'b0; // [RQ20]
        end
        // Interrupt on falling active with run clear, unless dead
        if (active_q && !active_d && !run_q && !dead_d) begin
            cint_d = 1'b1; // [RQ22]
        end
        if (dead_d) begin
            cint_d = 1'b0; // [RQ23]
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_q <= ST_IDLE;
            run_q <= 1'b0;
            wake_q <= 1'b0;
            dead_q <= 1'b0;
            active_q <= 1'b0; // [RQ20]
            evt_q <= `DCSC_EVT_NO_STATUS;
            spd_q <= 3'h0;
            ptr_q <= 32'h00000000;
            busy_q <= 1'b0;
            flush_q <= 1'b0;
            cint_q <= 1'b0;
            uint_q <= 1'b0;
            fetch_addr_q <= 32'h00000000;
            fetch_q <= 1'b0;
        end else if (clk_en) begin
            if (soft_reset) begin
                st_q <= ST_IDLE;
                run_q <= 1'b0;
                wake_q <= 1'b0;
                dead_q <= 1'b0;
                active_q <= 1'b0; // [RQ20]
                busy_q <= 1'b0;
                flush_q <= 1'b0;
                cint_q <= 1'b0;
                uint_q <= 1'b0;
                fetch_q <= 1'b0;
            end else begin
                st_q <= st_d;
                run_q <= run_d;
                wake_q <= wake_d;
                dead_q <= dead_d;
                active_q <= active_d;
                evt_q <= evt_d;
                spd_q <= spd_d;
                ptr_q <= ptr_d;
                busy_q <= busy_d;
                flush_q <= flush_d;
                cint_q <= cint_d;
                uint_q <= uint_d;
                fetch_addr_q <= fetch_addr_d;
                fetch_q <= fetch_d;
            end
        end
    end

    // Registered read views and strobes
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctl_rdata <= 32'h00000000;
            descriptor_list_pointer <= 32'h00000000;
            desc_fetch_req <= 1'b0;
            desc_fetch_addr <= 32'h00000000;
            rx_busy_ack <= 1'b0;
            rx_flush <= 1'b0;
            context_int_event <= 1'b0;
            unrecoverable_int_event <= 1'b0;
            status_word <= 16'h0000;
        end else if (clk_en) begin
            ctl_rdata <= {16'h0000, run_d, 2'h0, wake_d, dead_d, active_d, 2'h0,
                (is_rx ? spd_d : 3'h0), evt_d}; // [RQ2]
            descriptor_list_pointer <= ptr_d; // [RQ25]
            desc_fetch_req <= fetch_d;
            desc_fetch_addr <= fetch_addr_d;
            rx_busy_ack <= busy_d;
            rx_flush <= flush_d;
            context_int_event <= cint_d;
            unrecoverable_int_event <= uint_d;
            status_word <= {run_d, 2'h0, wake_d, dead_d, active_d, 2'h0,
                (is_rx ? spd_d : 3'h0), evt_d}; // [RQ1]
        end
    end
endmodule

/* verification/dcsc_context_props.sv */
// Concurrent checks on the ports of the context control block
`timescale 1ns/1ps
module dcsc_context_props (
    input wire clk,
    input wire rstn,
    input wire clk_en,
    input wire soft_reset,
    input wire [1:0] ctx_kind,
    input wire ctl_wr_set,
    input wire ctl_wr_clr,
    input wire [31:0] ctl_wdata,
    input wire ptr_wr,
    input wire [31:0] ptr_wdata,
    input wire serial_bus_reset,
    input wire [3:0] max_count,
    input wire rx_busy_ack,
    input wire rx_flush,
    input wire [31:0] ctl_rdata,
    input wire [31:0] descriptor_list_pointer,
    input wire desc_fetch_req,
    input wire [31:0] desc_fetch_addr,
    input wire context_int_event,
    input wire unrecoverable_int_event,
    input wire [15:0] status_word
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    wire ok = clk_en && !soft_reset;
    wire [3:0] cnt = descriptor_list_pointer[3:0];
    wire good = cnt != 4'h0 && cnt <= max_count;
    wire start = ok && ctl_wr_set && ctl_wdata[15] && !ctl_wdata[12] && !ctl_wr_clr && !ctl_rdata[15] && !ctl_rdata[10];
    status_copy_a: assert property (status_word == ctl_rdata[15:0])
        else $error("status word differs from control word");
    no_reserved_a: assert property (!(ctl_rdata[4:0] inside {5'h01, 5'h0C, 5'h0D, 5'h10, 5'h13, 5'h17,
        5'h18, 5'h19, 5'h1A, 5'h1C, 5'h1F})) else $error("reserved event code shown");
    run_start_a: assert property (start && good |-> ##2 ctl_rdata[10])
        else $error("run did not raise active");
    first_fetch_a: assert property (start && good |-> ##[2:3] (desc_fetch_req &&
        desc_fetch_addr == {descriptor_list_pointer[31:4], 4'h0})) else $error("first fetch missing or misaddressed");
    bad_count_a: assert property (start && !good |-> ##2 (ctl_rdata[11] && !ctl_rdata[10] &&
        ctl_rdata[4:0] == 5'h0E)) else $error("bad count not made dead");
    dead_state_a: assert property (ctl_rdata[11] |-> ctl_rdata[15] && !ctl_rdata[10])
        else $error("dead with active or without run");
    wake_idle_a: assert property (ok && ctl_wr_set && ctl_wdata[12] && !ctl_wdata[15] && !ctl_rdata[15]
        |-> ##2 (!ctl_rdata[10] && !ctl_rdata[12])) else $error("wake acted while stopped");
    stop_irq_a: assert property ($fell(ctl_rdata[10]) && !ctl_rdata[15] && !$past(soft_reset)
        && !$past(soft_reset, 2) |-> context_int_event) else $error("no interrupt on stop");
    dead_quiet_a: assert property ($rose(ctl_rdata[11]) |-> !context_int_event ##1 !context_int_event)
        else $error("context interrupt with dead");
    bus_reset_at_a: assert property (ok && serial_bus_reset && ctx_kind == 2'h0 && !ctl_wr_set
        |-> ##2 !ctl_rdata[10]) else $error("bus reset left transmit active");
    busy_flush_a: assert property (rx_busy_ack |-> rx_flush && ctl_rdata[10] && ctx_kind == 2'h1)
        else $error("busy answer without flush");
    run_clear_a: assert property (ok && ctl_wr_clr && ctl_wdata[15] && !ctl_wr_set
        |-> ##2 (!ctl_rdata[15] && !ctl_rdata[11])) else $error("run or dead stuck");
    ptr_load_a: assert property (ok && ptr_wr && !ctl_rdata[15] && !ctl_rdata[10] && !ctl_wr_set
        |-> ##2 descriptor_list_pointer == $past(ptr_wdata, 2)) else $error("pointer not loaded");
    cover property (start && good);
    cover property ($fell(ctl_rdata[10]) && ctl_rdata[15]);
    cover property ($rose(ctl_rdata[11]));
    cover property (rx_busy_ack);
endmodule

/* verification/dcsc_host_mem.sv */
// Host memory model answering descriptor fetches with branch words
`timescale 1ns/1ps
module dcsc_host_mem (
    input wire clk,
    input wire rstn,
    input wire desc_fetch_req,
    input wire [31:0] desc_fetch_addr,
    input wire [3:0] lat,
    output reg desc_done,
    output reg [31:0] desc_branch,
    output reg desc_int_req
);
    reg [31:0] mem [0:15];
    reg [31:0] addr_q;
    reg [3:0] cnt_q;
    reg busy_q;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            desc_done <= 1'b0;
            desc_branch <= 32'h0;
            desc_int_req <= 1'b0;
            addr_q <= 32'h0;
            cnt_q <= 4'h0;
            busy_q <= 1'b0;
        end else begin
            desc_done <= 1'b0;
            desc_branch <= ~desc_branch;
            if (desc_fetch_req) begin
                busy_q <= 1'b1;
                cnt_q <= lat;
                addr_q <= desc_fetch_addr;
            end else if (busy_q && cnt_q != 4'h0) begin
                cnt_q <= cnt_q - 4'h1;
            end else if (busy_q) begin
                // Memory read at answer time so appended lists are seen
                busy_q <= 1'b0;
                desc_done <= 1'b1;
                desc_branch <= mem[addr_q[7:4]];
            end
        end
    end
endmodule

/* verification/dma_context_state_control_test.sv */
// Self-checking bench for the context control block
`timescale 1ns/1ps
module dma_context_state_control_test;
    reg clk = 0, rstn = 0, clk_en = 1, soft_reset = 0, buffer_fill_cfg = 0, ctl_wr_set = 0, ctl_wr_clr = 0;
    reg ptr_wr = 0, serial_bus_reset = 0, pkt_done = 0, pkt_in_progress = 0, safe_point = 0, rx_arrival = 0;
    reg fatal_err = 0;
    reg [1:0] ctx_kind = 0, pkt_last_busy = 0;
    reg [2:0] pkt_speed = 0;
    reg [3:0] max_count = 4'h4, pkt_src = 0, fatal_src = 0, lat = 0;
    reg [4:0] pkt_ack = 0;
    reg [31:0] ctl_wdata = 0, ptr_wdata = 0;
    wire desc_done, desc_int_req, desc_fetch_req, rx_busy_ack, rx_flush;
    wire context_int_event, unrecoverable_int_event;
    wire [31:0] desc_branch, ctl_rdata, descriptor_list_pointer, desc_fetch_addr;
    wire [15:0] status_word;
    integer error_cnt = 0, num_checks = 0, i, n, nf, ni, nu, nb;
    localparam [79:0] EVT = {5'h0E, 5'h11, 5'h14, 5'h11, 5'h09, 5'h0F, 5'h0A, 5'h05,
        5'h02, 5'h0B, 5'h04, 5'h03, 5'h08, 5'h07, 5'h06, 5'h00};
    dcsc_context dut (.*);
    dcsc_host_mem p (.clk(clk), .rstn(rstn), .desc_fetch_req(desc_fetch_req), .desc_fetch_addr(desc_fetch_addr),
        .lat(lat), .desc_done(desc_done), .desc_branch(desc_branch), .desc_int_req(desc_int_req));
    initial begin
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        nf = nf + desc_fetch_req;
        ni = ni + context_int_event;
        nu = nu + unrecoverable_int_event;
        nb = nb + (rx_busy_ack & rx_flush);
    end
    function [4:0] ev(input [3:0] s, input [4:0] a, input [1:0] b);
        if (s == 4'hD) ev = 5'h14 + b;
        else if (s != 4'hC) ev = EVT[s * 5 +: 5];
        else if (a == 5'h10 || a == 5'h13 || a == 5'h1C || a == 5'h1F || (a >= 5'h17 && a <= 5'h1A)) ev = 5'h0E;
        else ev = a;
    endfunction
    task tk(input integer k);
        repeat (k) begin
            @(posedge clk);
            #1;
        end
    endtask
    task chk(input [95:0] nm, input [31:0] e, input [31:0] g);
        num_checks = num_checks + 1;
        if (g !== e) begin
            error_cnt = error_cnt + 1;
            $display("ERROR %0s expected %h seen %h", nm, e, g);
        end
    endtask
    task rst(input [1:0] k, input b);
        rstn = 0;
        ctx_kind = k;
        buffer_fill_cfg = b;
        tk(5);
        rstn = 1;
        nf = 0; ni = 0; nu = 0; nb = 0;
        tk(1);
    endtask
    task wr(input s, input [31:0] d);
        ctl_wr_set = s;
        ctl_wr_clr = !s;
        ctl_wdata = d;
        tk(1);
        ctl_wr_set = 0;
        ctl_wr_clr = 0;
        tk(1);
    endtask
    task ld(input [31:0] v);
        ptr_wdata = v;
        ptr_wr = 1;
        tk(1);
        ptr_wr = 0;
    endtask
    task go(input [1:0] k, input b);
        rst(k, b);
        ld(32'h12);
        wr(1, 32'h8000);
        tk(1);
        chk("active", 1, ctl_rdata[10]);
    endtask
    task idle;
        for (n = 0; n < 40 && ctl_rdata[10] !== 1'b0; n = n + 1) tk(1);
    endtask
    task conclude;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #500000;
        error_cnt = error_cnt + 1;
        conclude;
    end
    initial begin
        n = $urandom(32'h1374);
        for (i = 0; i < 16; i = i + 1) p.mem[i] = 32'h102;
        rst(0, 0);
        chk("reset", 0, ctl_rdata);
        wr(1, 32'h1000);
        chk("wake idle", 0, ctl_rdata[12:10]);
        for (i = 0; i < 20; i = i + 1) begin
            lat = 4'($urandom % 4);
            go(3, 0);
            pkt_src = (i < 16) ? i[3:0] : 4'hC;
            pkt_ack = 5'h10 | 5'($urandom % 16);
            pkt_last_busy = 2'($urandom % 3);
            pkt_speed = 3'($urandom);
            pkt_done = 1;
            tk(1);
            pkt_done = 0;
            tk(2);
            chk("event", ev(pkt_src, pkt_ack, pkt_last_busy), ctl_rdata[4:0]);
            chk("speed", pkt_speed, ctl_rdata[7:5]);
        end
        p.mem[1] = 32'h20;
        lat = 1;
        go(0, 0);
        idle;
        chk("fetches", 2, nf);
        chk("list end", 6'h20, ctl_rdata[15:10]);
        wr(1, 32'h1000);
        idle;
        chk("rewake", 3, nf);
        chk("wake clear", 6'h20, ctl_rdata[15:10]);
        chk("no irq", 0, ni);
        lat = 6;
        go(0, 0);
        for (n = 0; n < 40 && desc_done !== 1'b1; n = n + 1) tk(1);
        p.mem[1] = 32'h103;
        tk(30);
        chk("append", 1, ctl_rdata[10]);
        chk("next addr", 32'h100, desc_fetch_addr);
        p.mem[1] = 32'h20;
        lat = 0;
        go(1, 0);
        tk(20);
        chk("rx park", 1, ctl_rdata[10]);
        rx_arrival = 1;
        tk(1);
        rx_arrival = 0;
        tk(3);
        chk("busy ack", 1, nb);
        go(1, 1);
        idle;
        chk("fill end", 0, ctl_rdata[10]);
        p.mem[1] = 32'h102;
        for (i = 0; i < 4; i = i + 1) begin
            go(i, 0);
            pkt_in_progress = 1;
            wr(0, 32'h8000);
            tk(6);
            chk("stop held", 1, ctl_rdata[10]);
            pkt_in_progress = 0;
            safe_point = 1;
            idle;
            safe_point = 0;
            tk(1);
            chk("stopped", 0, ctl_rdata[10]);
            chk("stop irq", 1, ni);
        end
        for (i = 0; i < 2; i = i + 1) begin
            rst(0, 0);
            ld(i ? 32'h15 : 32'h10);
            wr(1, 32'h8000);
            tk(1);
            chk("dead", 6'h22, ctl_rdata[15:10]);
            chk("unknown", 5'h0E, ctl_rdata[4:0]);
            chk("unrec", 1, nu);
            wr(0, 32'h8000);
            chk("undead", 0, ctl_rdata[15:10]);
        end
        go(2, 0);
        fatal_src = 4'h1;
        fatal_err = 1;
        tk(1);
        fatal_err = 0;
        tk(2);
        chk("fatal", 6'h22, ctl_rdata[15:10]);
        chk("fatal code", 5'h06, ctl_rdata[4:0]);
        chk("fatal irq", 2, nu * 2 + ni);
        for (i = 0; i < 2; i = i + 1) begin
            go(i * 3, 0);
            serial_bus_reset = 1;
            tk(1);
            serial_bus_reset = 0;
            tk(2);
            chk("bus reset", i, ctl_rdata[10]);
        end
        soft_reset = 1;
        tk(1);
        soft_reset = 0;
        tk(2);
        chk("soft reset", 0, ctl_rdata[15:10]);
        conclude;
    end
endmodule
bind dcsc_context dcsc_context_props chk_i (.*);
